// ### sensor_regs_pkg.sv
// constants of the sensor register bank: pointers, field positions, reset values, conversion timing
package sensor_regs_pkg;

   // ------------------------------------------------------------
   // register pointers
   // ------------------------------------------------------------
   localparam logic [7:0] PTR_TEMP        = 8'h00;
   localparam logic [7:0] PTR_HUM         = 8'h01;
   localparam logic [7:0] PTR_CFG         = 8'h02;
   localparam logic [7:0] PTR_SERIAL_HIGH = 8'hfb;
   localparam logic [7:0] PTR_SERIAL_MID  = 8'hfc;
   localparam logic [7:0] PTR_SERIAL_LOW  = 8'hfd;
   localparam logic [7:0] PTR_MAKER       = 8'hfe;
   localparam logic [7:0] PTR_PART        = 8'hff;
   localparam logic [7:0] PTR_RESET       = 8'h00;

   // ------------------------------------------------------------
   // configuration field positions and reset value
   // ------------------------------------------------------------
   localparam int          CFG_SOFT_RESET = 15;
   localparam int          CFG_HEATER     = 13;
   localparam int          CFG_MODE_BOTH  = 12;
   localparam int          CFG_SUPPLY_LOW = 11;
   localparam int          CFG_TEMP_RESOLUTION_SEL       = 10;
   localparam int          CFG_MOISTURE_RESOLUTION_SEL_HI    = 9;
   localparam int          CFG_MOISTURE_RESOLUTION_SEL_LO    = 8;
   localparam logic [15:0] CFG_RESET      = 16'h1000;

   // ------------------------------------------------------------
   // result and serial layout
   // ------------------------------------------------------------
   localparam int SAMPLE_W     = 14;
   localparam int WORD_W       = 16;
   localparam int SERIAL_W     = 41;
   localparam int SERIAL_LOW_W = 9;

   localparam logic [1:0] MOISTURE_RESOLUTION_SEL_14 = 2'h0;
   localparam logic [1:0] MOISTURE_RESOLUTION_SEL_11 = 2'h1;
   localparam logic [1:0] MOISTURE_RESOLUTION_SEL_8  = 2'h2;

   // ------------------------------------------------------------
   // conversion timing, times in ns, counts in clk cycles
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int CONV_14_NS    = 6400;
   localparam int CONV_11_NS    = 3700;
   localparam int CONV_8_NS     = 2600;
   localparam int CONV_14_CYC   = (CONV_14_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_11_CYC   = (CONV_11_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_8_CYC    = (CONV_8_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 12;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_TEMP = 2'b01,
      SEQ_HUM  = 2'b10
   } seq_state_t;

endpackage : sensor_regs_pkg

// ### acq_if.sv
// link between the register bank and the acquisition sequencer
`timescale 1ns/1ps
interface acq_if;
   logic                                     start;
   logic                                     abort;
   logic                                     start_hum_only;
   logic                                     mode_both;
   logic                                     temp_res_sel;
   logic [1:0]                               moisture_res_sel;
   logic                                     busy;
   logic                                     temp_done;
   logic                                     hum_done;
   logic [sensor_regs_pkg::WORD_W-1:0]       temp_word;
   logic [sensor_regs_pkg::WORD_W-1:0]       hum_word;

   modport regs (output start, abort, start_hum_only, mode_both, temp_res_sel, moisture_res_sel,
                 input busy, temp_done, hum_done, temp_word, hum_word);
   modport seq  (input start, abort, start_hum_only, mode_both, temp_res_sel, moisture_res_sel,
                 output busy, temp_done, hum_done, temp_word, hum_word);
endinterface : acq_if

// ### acq_sequencer.sv
// acquisition sequencer: times conversions and captures left-aligned results
`timescale 1ns/1ps
module acq_sequencer (
   input  wire logic                                   clk,
   input  wire logic                                   sys_rst,
   input  wire logic [sensor_regs_pkg::SAMPLE_W-1:0]   temp_sample,
   input  wire logic [sensor_regs_pkg::SAMPLE_W-1:0]   hum_sample,
   acq_if.seq                                          acq
);

   sensor_regs_pkg::seq_state_t               state;
   logic                                      both_latched;
   logic                                      temp_resolution_sel_latched;
   logic [1:0]                                moisture_resolution_sel_latched;
   logic [sensor_regs_pkg::CNT_W-1:0]         count;
   logic [sensor_regs_pkg::CNT_W-1:0]         temp_load;
   logic [sensor_regs_pkg::CNT_W-1:0]         hum_load;
   logic                                      count_zero;

   // ------------------------------------------------------------
   // conversion length per resolution; only time changes, never width
   // ------------------------------------------------------------
   assign temp_load  = acq.temp_res_sel ? sensor_regs_pkg::CNT_W'(sensor_regs_pkg::CONV_11_CYC - 1)
                                        : sensor_regs_pkg::CNT_W'(sensor_regs_pkg::CONV_14_CYC - 1);
   assign hum_load   = (moisture_resolution_sel_latched == sensor_regs_pkg::MOISTURE_RESOLUTION_SEL_8)  ? sensor_regs_pkg::CNT_W'(sensor_regs_pkg::CONV_8_CYC - 1) :
                       (moisture_resolution_sel_latched == sensor_regs_pkg::MOISTURE_RESOLUTION_SEL_11) ? sensor_regs_pkg::CNT_W'(sensor_regs_pkg::CONV_11_CYC - 1)
                                                                  : sensor_regs_pkg::CNT_W'(sensor_regs_pkg::CONV_14_CYC - 1);
   assign count_zero = (count == '0);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state         <= sensor_regs_pkg::SEQ_IDLE;
         both_latched  <= 1'b0;
         temp_resolution_sel_latched  <= 1'b0;
         moisture_resolution_sel_latched  <= 2'h0;
         count         <= '0;
         acq.busy      <= 1'b0;
         acq.temp_done <= 1'b0;
         acq.hum_done  <= 1'b0;
         acq.temp_word <= 16'h0000;
         acq.hum_word  <= 16'h0000;
      end else begin
         acq.temp_done <= 1'b0;
         acq.hum_done  <= 1'b0;
         if (acq.abort) begin
            state    <= sensor_regs_pkg::SEQ_IDLE;
            acq.busy <= 1'b0;
         end else begin
            unique case (state)
               sensor_regs_pkg::SEQ_IDLE: begin
                  if (acq.start) begin
                     both_latched <= acq.mode_both;
                     temp_resolution_sel_latched <= acq.temp_res_sel;
                     moisture_resolution_sel_latched <= acq.moisture_res_sel;
                     acq.busy     <= 1'b1;
                     if (acq.start_hum_only) begin
                        state <= sensor_regs_pkg::SEQ_HUM;
                        count <= (acq.moisture_res_sel == sensor_regs_pkg::MOISTURE_RESOLUTION_SEL_8)
                                 ? sensor_regs_pkg::CNT_W'(sensor_regs_pkg::CONV_8_CYC - 1)
                                 : (acq.moisture_res_sel == sensor_regs_pkg::MOISTURE_RESOLUTION_SEL_11)
                                 ? sensor_regs_pkg::CNT_W'(sensor_regs_pkg::CONV_11_CYC - 1)
                                 : sensor_regs_pkg::CNT_W'(sensor_regs_pkg::CONV_14_CYC - 1);
                     end else begin
                        state <= sensor_regs_pkg::SEQ_TEMP;
                        count <= temp_load;
                     end
                  end
               end
               sensor_regs_pkg::SEQ_TEMP: begin
                  if (count_zero) begin
                     acq.temp_word <= {temp_sample, 2'b00};
                     acq.temp_done <= 1'b1;
                     if (both_latched) begin
                        state <= sensor_regs_pkg::SEQ_HUM;
                        count <= hum_load;
                     end else begin
                        state    <= sensor_regs_pkg::SEQ_IDLE;
                        acq.busy <= 1'b0;
                     end
                  end else begin
                     count <= count - 1'b1;
                  end
               end
               sensor_regs_pkg::SEQ_HUM: begin
                  if (count_zero) begin
                     acq.hum_word <= {hum_sample, 2'b00};
                     acq.hum_done <= 1'b1;
                     state        <= sensor_regs_pkg::SEQ_IDLE;
                     acq.busy     <= 1'b0;
                  end else begin
                     count <= count - 1'b1;
                  end
               end
               default: begin
                  state    <= sensor_regs_pkg::SEQ_IDLE;
                  acq.busy <= 1'b0;
               end
            endcase
         end
      end
   end

   // temp_resolution_sel_latched kept for a future accuracy model; timing uses the live select at start
   logic unused_temp_resolution_sel;
   assign unused_temp_resolution_sel = temp_resolution_sel_latched;

endmodule : acq_sequencer

// ### sensor_regs.sv
// register bank of the humidity and temperature sensor, reached through an 8-bit pointer
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module sensor_regs #(
   parameter logic [sensor_regs_pkg::SERIAL_W-1:0] UNIQUE_PART_NUMBER = 41'h0_0123_4567_89, // arbitrary
   parameter logic [15:0]                          MAKER_CODE         = 16'ha5c3,         // arbitrary
   parameter logic [15:0]                          PART_CODE          = 16'h0b17          // arbitrary
) (
   input  wire logic                                 clk,
   input  wire logic                                 sys_rst,
   input  wire logic                                 ptr_wr,
   input  wire logic [7:0]                           ptr_value,
   input  wire logic                                 data_wr,
   input  wire logic [15:0]                          data_in,
   input  wire logic                                 data_rd,
   input  wire logic                                 supply_low,
   input  wire logic [sensor_regs_pkg::SAMPLE_W-1:0] temp_sample,
   input  wire logic [sensor_regs_pkg::SAMPLE_W-1:0] hum_sample,
   output      logic [15:0]                          data_out,
   output      logic                                 ack,
   output      logic                                 nack,
   output      logic                                 heater_on,
   output      logic                                 busy
);

   acq_if acq ();

   logic [7:0]  pointer;
   logic        mode_both;
   logic        temp_res_sel;
   logic [1:0]  moisture_res_sel;
   logic        supply_low_flag;
   logic        temp_fresh;
   logic        hum_fresh;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire is_temp   = (pointer == sensor_regs_pkg::PTR_TEMP);
   wire is_hum    = (pointer == sensor_regs_pkg::PTR_HUM);
   wire is_cfg    = (pointer == sensor_regs_pkg::PTR_CFG);
   wire ptr_known = (ptr_value <= sensor_regs_pkg::PTR_CFG) || (ptr_value >= sensor_regs_pkg::PTR_SERIAL_HIGH);
   wire ptr_meas  = ptr_wr && (ptr_value <= sensor_regs_pkg::PTR_HUM);
   wire cfg_write = data_wr && is_cfg;
   wire soft_rst  = cfg_write && data_in[sensor_regs_pkg::CFG_SOFT_RESET];

   // ------------------------------------------------------------
   // measurement control
   // ------------------------------------------------------------
   // a pointer to a result register while busy only aborts; the host re-triggers afterwards
   wire result_wr = data_wr && (is_temp || is_hum);
   assign acq.abort            = (ptr_meas && acq.busy) || (result_wr && acq.busy) || soft_rst;
   assign acq.start            = ptr_meas && !acq.busy && !soft_rst;
   // the humidity pointer alone triggers a humidity-only run only in single mode; in combined mode it starts both
   assign acq.start_hum_only   = (ptr_value == sensor_regs_pkg::PTR_HUM) && !mode_both;
   assign acq.mode_both        = mode_both;
   assign acq.temp_res_sel     = temp_res_sel;
   assign acq.moisture_res_sel = moisture_res_sel;
   wire start_temp = acq.start && !acq.start_hum_only;
   wire start_hum  = acq.start && (acq.start_hum_only || mode_both);

   acq_sequencer u_seq (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .temp_sample (temp_sample),
      .hum_sample  (hum_sample),
      .acq         (acq)
   );

   // ------------------------------------------------------------
   // readback values
   // ------------------------------------------------------------
   wire [15:0] hum_result   = {acq.hum_word[15:2], 2'b00};
   wire [15:0] temp_result  = {acq.temp_word[15:2], 2'b00};
   wire [15:0] cfg_readback = {1'b0, 1'b0, heater_on, mode_both, supply_low_flag,
                               temp_res_sel, moisture_res_sel, 8'h00};
   wire [15:0] serial_high  = UNIQUE_PART_NUMBER[40:25];
   wire [15:0] serial_mid   = UNIQUE_PART_NUMBER[24:9];
   wire [15:0] serial_low   = {UNIQUE_PART_NUMBER[8:0], 7'h00};

   wire [15:0] read_value = is_temp ? temp_result :
                            is_hum  ? hum_result :
                            is_cfg  ? cfg_readback :
                            (pointer == sensor_regs_pkg::PTR_SERIAL_HIGH) ? serial_high :
                            (pointer == sensor_regs_pkg::PTR_SERIAL_MID)  ? serial_mid :
                            (pointer == sensor_regs_pkg::PTR_SERIAL_LOW)  ? serial_low :
                            (pointer == sensor_regs_pkg::PTR_MAKER)       ? MAKER_CODE :
                            (pointer == sensor_regs_pkg::PTR_PART)        ? PART_CODE : 16'h0000;
   wire read_ok  = (is_temp && temp_fresh) || (is_hum && hum_fresh) || (!is_temp && !is_hum && (pointer
                   <= sensor_regs_pkg::PTR_CFG || pointer >= sensor_regs_pkg::PTR_SERIAL_HIGH));
   wire write_ok = is_cfg;

   wire next_ack  = (ptr_wr && ptr_known) || (data_rd && read_ok) || (data_wr && write_ok);
   wire next_nack = (ptr_wr && !ptr_known) || (data_rd && !read_ok) || (data_wr && !write_ok);

   // ------------------------------------------------------------
   // bus answer
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pointer  <= sensor_regs_pkg::PTR_RESET;
         data_out <= 16'h0000;
         ack      <= 1'b0;
         nack     <= 1'b0;
      end else begin
         ack  <= next_ack;
         nack <= next_nack;
         if (ptr_wr) begin
            pointer <= ptr_value;
         end
         if (data_rd && read_ok) begin
            data_out <= read_value;
         end
      end
   end

   // ------------------------------------------------------------
   // configuration fields
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         heater_on        <= sensor_regs_pkg::CFG_RESET[sensor_regs_pkg::CFG_HEATER];
         mode_both        <= sensor_regs_pkg::CFG_RESET[sensor_regs_pkg::CFG_MODE_BOTH];
         temp_res_sel     <= sensor_regs_pkg::CFG_RESET[sensor_regs_pkg::CFG_TEMP_RESOLUTION_SEL];
         moisture_res_sel <= sensor_regs_pkg::CFG_RESET[sensor_regs_pkg::CFG_MOISTURE_RESOLUTION_SEL_HI:sensor_regs_pkg::CFG_MOISTURE_RESOLUTION_SEL_LO];
         supply_low_flag  <= 1'b0;
      end else begin
         supply_low_flag <= supply_low;
         if (soft_rst) begin
            heater_on        <= sensor_regs_pkg::CFG_RESET[sensor_regs_pkg::CFG_HEATER];
            mode_both        <= sensor_regs_pkg::CFG_RESET[sensor_regs_pkg::CFG_MODE_BOTH];
            temp_res_sel     <= sensor_regs_pkg::CFG_RESET[sensor_regs_pkg::CFG_TEMP_RESOLUTION_SEL];
            moisture_res_sel <= sensor_regs_pkg::CFG_RESET[sensor_regs_pkg::CFG_MOISTURE_RESOLUTION_SEL_HI:sensor_regs_pkg::CFG_MOISTURE_RESOLUTION_SEL_LO];
         end else if (cfg_write) begin
            heater_on        <= data_in[sensor_regs_pkg::CFG_HEATER];
            mode_both        <= data_in[sensor_regs_pkg::CFG_MODE_BOTH];
            temp_res_sel     <= data_in[sensor_regs_pkg::CFG_TEMP_RESOLUTION_SEL];
            moisture_res_sel <= data_in[sensor_regs_pkg::CFG_MOISTURE_RESOLUTION_SEL_HI:sensor_regs_pkg::CFG_MOISTURE_RESOLUTION_SEL_LO];
         end
      end
   end

   // ------------------------------------------------------------
   // result freshness: a completed conversion outranks a new trigger
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         temp_fresh <= 1'b0;
         hum_fresh  <= 1'b0;
         busy       <= 1'b0;
      end else begin
         busy <= acq.busy;
         if (acq.temp_done) begin
            temp_fresh <= 1'b1;
         end else if (start_temp) begin
            temp_fresh <= 1'b0;
         end
         if (acq.hum_done) begin
            hum_fresh <= 1'b1;
         end else if (start_hum) begin
            hum_fresh <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_hum_low_zero: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && is_hum && hum_fresh |=> ack && data_out[1:0] == 2'b00)
      else $error("humidity low bits not zero");

   a_hum_read_only: assert property (@(posedge clk) disable iff (sys_rst)
      data_wr && is_hum |=> nack && !ack)
      else $error("humidity register accepted a write");

   a_soft_reset: assert property (@(posedge clk) disable iff (sys_rst)
      soft_rst |=> !heater_on && mode_both && !temp_res_sel && moisture_res_sel == 2'h0 && !acq.busy ##1 !busy)
      else $error("soft reset did not restore fields");

   a_heater_follow: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_write && !soft_rst |=> heater_on == $past(data_in[13]) && temp_res_sel == $past(data_in[10]))
      else $error("heater or resolution did not follow write");

   a_single_stop: assert property (@(posedge clk) disable iff (sys_rst)
      start_temp && !mode_both |=> (acq.busy && !acq.hum_done) [*8])
      else $error("single temperature run touched humidity");

   a_seq_order: assert property (@(posedge clk) disable iff (sys_rst)
      acq.temp_done && !$past(acq.abort) && u_seq.both_latched |-> acq.busy && !hum_fresh)
      else $error("humidity not converted after temperature");

   a_supply_flag: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && is_cfg |=> data_out[11] == $past(supply_low, 2))
      else $error("supply flag readback wrong");

   a_serial_low: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && pointer == sensor_regs_pkg::PTR_SERIAL_LOW |=> ack && data_out[6:0] == 7'h00)
      else $error("serial low reserved bits set");

   a_part_code: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && pointer == sensor_regs_pkg::PTR_PART |=> data_out == PART_CODE && data_out != MAKER_CODE)
      else $error("part code readback wrong");

   a_abort_run: assert property (@(posedge clk) disable iff (sys_rst)
      ptr_meas && acq.busy |=> !acq.busy ##1 !busy)
      else $error("measurement not aborted");

   a_nack_stale: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && is_hum && !hum_fresh |=> nack && !ack && $stable(data_out))
      else $error("stale humidity read acknowledged");

   a_answer_one: assert property (@(posedge clk) disable iff (sys_rst)
      (ptr_wr || data_wr || data_rd) |=> ack != nack)
      else $error("strobe not answered by exactly one of ack and nack");

   a_serial_high: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && pointer == sensor_regs_pkg::PTR_SERIAL_HIGH |=> ack && data_out == UNIQUE_PART_NUMBER[40:25])
      else $error("serial high readback wrong");

   a_serial_mid: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && pointer == sensor_regs_pkg::PTR_SERIAL_MID |=> ack && data_out == UNIQUE_PART_NUMBER[24:9])
      else $error("serial mid readback wrong");

   a_maker_code: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && pointer == sensor_regs_pkg::PTR_MAKER |=> ack && data_out == MAKER_CODE)
      else $error("maker code readback wrong");

   a_cfg_reserved: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && is_cfg |=> data_out[15:14] == 2'b00 && data_out[7:0] == 8'h00)
      else $error("config reset or reserved bits read as one");

   a_moisture_resolution_sel_field: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_write && !soft_rst |=> moisture_res_sel == $past(data_in[9:8]) && mode_both == $past(data_in[12]))
      else $error("humidity resolution or mode did not follow write");

   a_hum_capture: assert property (@(posedge clk) disable iff (sys_rst)
      acq.hum_done |-> acq.hum_word == {$past(hum_sample), 2'b00})
      else $error("humidity sample not stored left aligned");

   a_temp_capture: assert property (@(posedge clk) disable iff (sys_rst)
      acq.temp_done |-> acq.temp_word == {$past(temp_sample), 2'b00})
      else $error("temperature sample not stored left aligned");

endmodule : sensor_regs

// ### host_model.sv
// host side model: one strobe at a time, waits for the answer
`timescale 1ns/1ps
module host_model (
   input  wire logic        clk,
   output      logic        ptr_wr,
   output      logic [7:0]  ptr_value,
   output      logic        data_wr,
   output      logic [15:0] data_in,
   output      logic        data_rd,
   input  wire logic        ack,
   input  wire logic        nack,
   input  wire logic [15:0] data_out
);
   initial begin
      {ptr_wr, data_wr, data_rd, ptr_value, data_in} = '0;
   end
   // kind 0 pointer, 1 data write, 2 read; ans is {nack, ack}
   task automatic xfer(input int kind, input logic [15:0] v, output logic [1:0] ans, output logic [15:0] rd);
      @(posedge clk) #1;
      ptr_value = v[7:0];
      data_in = v & 16'hbf00;
      ptr_wr = (kind == 0);
      data_wr = (kind == 1);
      data_rd = (kind == 2);
      @(posedge clk) #1;
      {ptr_wr, data_wr, data_rd} = 3'b000;
      // released lines must not keep looking valid
      ptr_value = ~ptr_value;
      data_in = ~data_in;
      if (!(ack | nack)) @(posedge clk) #1;
      ans = {nack, ack};
      rd = data_out;
   endtask : xfer
endmodule : host_model

// ### test_sensor_regs.sv
// self-checking bench of the sensor register bank
`timescale 1ns/1ps
module test_sensor_regs;
   localparam logic [40:0] SN = 41'h1_5a3c_9e71_2d; // arbitrary
   localparam logic [15:0] MK = 16'h3c5a;           // arbitrary
   localparam logic [15:0] PC = 16'h7e21;           // arbitrary
   logic        clk, sys_rst, ptr_wr, data_wr, data_rd, supply_low, ack, nack, heater_on, busy;
   logic [7:0]  ptr_value;
   logic [15:0] data_in, data_out, rd;
   logic [13:0] temp_sample, hum_sample;
   logic [1:0]  ans;
   int          fails = 0, check_count = 0, cycles = 0;

   sensor_regs #(.UNIQUE_PART_NUMBER(SN), .MAKER_CODE(MK), .PART_CODE(PC)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .ptr_wr(ptr_wr), .ptr_value(ptr_value), .data_wr(data_wr),
      .data_in(data_in), .data_rd(data_rd), .supply_low(supply_low), .temp_sample(temp_sample),
      .hum_sample(hum_sample), .data_out(data_out), .ack(ack), .nack(nack), .heater_on(heater_on), .busy(busy));
   host_model u_host (.clk(clk), .ptr_wr(ptr_wr), .ptr_value(ptr_value), .data_wr(data_wr), .data_in(data_in),
      .data_rd(data_rd), .ack(ack), .nack(nack), .data_out(data_out));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd_reg(input logic [7:0] p);
      u_host.xfer(0, {8'h00, p}, ans, rd);
      u_host.xfer(2, 16'h0000, ans, rd);
   endtask : rd_reg
   task automatic wait_idle;
      // port busy rises one edge after the trigger is taken, so let that edge pass first
      @(posedge clk) #1;
      // no new trigger before the run ends; the one-per-second pace is scaled away here
      for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk) #1;
   endtask : wait_idle
   task automatic ids_test;
      logic [15:0] exp [5];
      exp = '{SN[40:25], SN[24:9], {SN[8:0], 7'h00}, MK, PC};
      for (int i = 0; i < 5; i++) begin
         rd_reg(8'hfb + i[7:0]);
         check(rd, exp[i]);
      end
      u_host.xfer(1, 16'h1234, ans, rd);
      check({14'h0, ans}, 16'h0002);
   endtask : ids_test
   task automatic cfg_test;
      rd_reg(sensor_regs_pkg::PTR_CFG);
      check(rd, sensor_regs_pkg::CFG_RESET);
      supply_low = 1'b1;
      // heater on, single mode, 11-bit temperature, 8-bit humidity
      u_host.xfer(1, 16'h2600, ans, rd);
      rd_reg(sensor_regs_pkg::PTR_CFG);
      check(rd, 16'h2e00);
      check({15'h0, heater_on}, 16'h0001);
   endtask : cfg_test
   task automatic meas_test;
      hum_sample = 14'h2a5b;
      u_host.xfer(0, 16'h0001, ans, rd);
      u_host.xfer(2, 16'h0000, ans, rd);
      check({14'h0, ans}, 16'h0002);
      wait_idle();
      u_host.xfer(2, 16'h0000, ans, rd);
      check(rd, {14'h2a5b, 2'b00});
      // host side scaling of the humidity word to whole percent
      check(16'((32'(rd) * 32'h64) >> 16), 16'h0042);
      // single mode temperature run at 11-bit resolution
      temp_sample = 14'h0abc;
      u_host.xfer(0, 16'h0000, ans, rd);
      wait_idle();
      u_host.xfer(2, 16'h0000, ans, rd);
      check({14'h0, ans}, 16'h0001);
      check(rd, {14'h0abc, 2'b00});
   endtask : meas_test
   task automatic both_test;
      u_host.xfer(0, 16'h0002, ans, rd);
      u_host.xfer(1, 16'h8000, ans, rd);
      check({15'h0, heater_on}, 16'h0000);
      rd_reg(sensor_regs_pkg::PTR_CFG);
      check(rd, 16'h1800);
      temp_sample = 14'h1111;
      u_host.xfer(0, 16'h0000, ans, rd);
      repeat (sensor_regs_pkg::CONV_14_CYC + 6) @(posedge clk);
      u_host.xfer(2, 16'h0000, ans, rd);
      check(rd, {14'h1111, 2'b00});
      check({15'h0, busy}, 16'h0001);
      u_host.xfer(0, 16'h0001, ans, rd);
      repeat (2) @(posedge clk) #1;
      check({15'h0, busy}, 16'h0000);
      u_host.xfer(2, 16'h0000, ans, rd);
      check({14'h0, ans}, 16'h0002);
      u_host.xfer(1, 16'h0000, ans, rd);
      check({14'h0, ans}, 16'h0002);
      // soft reset in the middle of a combined run must drop it
      u_host.xfer(0, 16'h0000, ans, rd);
      u_host.xfer(0, 16'h0002, ans, rd);
      check({15'h0, busy}, 16'h0001);
      u_host.xfer(1, 16'h8000, ans, rd);
      repeat (2) @(posedge clk) #1;
      check({15'h0, busy}, 16'h0000);
   endtask : both_test
   task automatic stop_test;
      $display("fails %0d check_count %0d", fails, check_count);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {sys_rst, supply_low, temp_sample, hum_sample} = {2'b10, 28'h0};
      repeat (20) @(posedge clk);
      #1 sys_rst = 1'b0;
      ids_test();
      cfg_test();
      meas_test();
      both_test();
      stop_test();
   end
   // the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles > 5000) begin
         fails++;
         stop_test();
      end
   end
endmodule : test_sensor_regs
